// ### src/ext_irq_defines.svh
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// Register byte addresses (one aligned 32-bit word each)
`define EXT_IRQ_OFF_CTRL 8'h28
`define EXT_IRQ_OFF_STATUS 8'h2C
`define EXT_IRQ_OFF_MASK 8'h30
`define EXT_IRQ_OFF_PEND 8'h34

// Sensitivity control field positions
`define EXT_IRQ_SENSE_B_HI 7
`define EXT_IRQ_SENSE_B_LO 6
`define EXT_IRQ_INVERT_SRC2 5
`define EXT_IRQ_SENSE_A_HI 4
`define EXT_IRQ_SENSE_A_LO 3
`define EXT_IRQ_INVERT_SRC0 2

// Writable bits of the control register; bits 1:0 stay zero
`define EXT_IRQ_CTRL_WMASK 8'hFC

// Status and mask layout: bits 3:0 sources, bit 4 refused control write
`define EXT_IRQ_STAT_REFUSED 4
`define EXT_IRQ_STAT_W 5

// Reset values
`define EXT_IRQ_CTRL_RST 8'h00
`define EXT_IRQ_STATUS_RST 5'h00
`define EXT_IRQ_MASK_RST 5'h00
`define EXT_IRQ_PEND_RST 4'h0

// Idle level of the pins before the first sample arrives (pull-up assumed)
`define EXT_IRQ_PIN_IDLE 1'b1

`endif

// ### src/ext_irq_pkg.sv
package ext_irq_pkg;

  typedef struct packed {
    logic rise;
    logic fall;
    logic low;
    logic high;
  } sense_s;

  // Non-inverted: 00 fall+low, 01 rise, 10 fall, 11 both.
  // Inverted swaps direction and level, except that 11 stays both edges.
  function automatic sense_s decode_sense(input logic [1:0] code, input logic inv);
    sense_s s;
    s.rise = (code == 2'h1) || (code == 2'h3);
    s.fall = (code == 2'h0) || (code == 2'h2) || (code == 2'h3);
    s.low = (code == 2'h0);
    s.high = 1'b0;
    if (inv && (code != 2'h3)) begin
      s.rise = ~s.rise;
      s.fall = ~s.fall;
      s.high = s.low;
      s.low = 1'b0;
    end
    return s;
  endfunction : decode_sense

endpackage : ext_irq_pkg

// ### src/ext_irq_pin_sync.sv
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module ext_irq_pin_sync #(
  parameter int unsigned WIDTH = 10
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [WIDTH-1:0] pins_in,
  output logic [WIDTH-1:0] pins_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_s;

  sync_s q;
  sync_s d;

  // The first stage feeds only the second stage
  always_comb begin
    d.meta = pins_in;
    d.stable = q.meta;
    pins_out = q.stable;
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= {(2 * WIDTH){`EXT_IRQ_PIN_IDLE}};
    end else begin
      q <= d;
    end
  end

endmodule : ext_irq_pin_sync

// ### src/ext_irq_pin_sense.sv
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module ext_irq_pin_sense #(
  parameter int unsigned PINS = 1
) (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [PINS-1:0] pins_in,
  input wire logic [1:0] mode_in,
  input wire logic invert_in,
  output logic edge_hit_out,
  output logic level_hit_out
);

  typedef struct packed {
    logic [PINS-1:0] prev;
  } sense_st_s;

  sense_st_s q;
  sense_st_s d;
  ext_irq_pkg::sense_s sel;

  // Each pin of a source is watched on its own and the hits are ORed
  always_comb begin
    sel = ext_irq_pkg::decode_sense(mode_in, invert_in);
    d.prev = pins_in;
    edge_hit_out = (sel.rise & (|(pins_in & ~q.prev))) |
                   (sel.fall & (|(~pins_in & q.prev)));
    level_hit_out = (sel.low & ~(&pins_in)) | (sel.high & (|pins_in));
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= {PINS{`EXT_IRQ_PIN_IDLE}};
    end else begin
      q <= d;
    end
  end

endmodule : ext_irq_pin_sense

// ### src/ext_irq_sensitivity.sv
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

// Functional notes
// - Four external sources, configured by two shared mode fields and two invert bits.
// - Source 0 from A3/E1, 1 from F2..0, 2 from B3..0, 3 from B4.
// - Control changes are taken only while both CPU level bits are one.
// - A changed field or invert bit clears the pending requests it affects.
// - Sensitivity control register resets to all zeros.
// - Bits 7:6 select sensitivity for sources 2 and 3.
// - Source 2 uninverted: 00 fall+low, 01 rise, 10 fall, 11 both.
// - Bit 5 inverts source 2: 00 rise+high, 01 fall, 10 rise, 11 both.
// - Source 3 always uses the uninverted mapping of bits 7:6.
// - Bits 4:3 select sensitivity for sources 0 and 1.
// - Source 0 uses bits 4:3, inverted by bit 2 like source 2.
// - Bit 2 affects only source 0; source 1 stays uninverted.
// - Rise plus high level exists only for sources 0 and 2.
// - Bit 2 inverts the A3/E1 source and is writable only at level 3.
// - Level 3 means both level bits set, which disables maskable interrupts.
module ext_irq_sensitivity (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic cpu_level_hi_in,
  input wire logic cpu_level_lo_in,
  input wire logic port_a3_in,
  input wire logic port_e1_in,
  input wire logic [2:0] port_f_in,
  input wire logic [4:0] port_b_in,
  input wire logic [3:0] ext_src_ack_in,
  output logic [3:0] ext_src_req_out,
  output logic irq_out
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic [`EXT_IRQ_STAT_W-1:0] mask;
    logic [`EXT_IRQ_STAT_W-1:0] status;
    logic [3:0] pend;
    logic [3:0] req;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } regs_s;

  regs_s q;
  regs_s d;

  logic [9:0] pins_raw;
  logic [9:0] pins_sync;
  logic [3:0] edge_hit;
  logic [3:0] level_hit;
  logic [3:0] hit;
  logic access;
  logic done;
  logic wr;
  logic wr_ctrl;
  logic level3;
  logic [7:0] ctrl_new;
  logic chg_b;
  logic chg_inv2;
  logic chg_a;
  logic chg_inv0;
  logic [3:0] pend_clr;
  logic refused;
  logic [`EXT_IRQ_STAT_W-1:0] events;
  logic [`EXT_IRQ_STAT_W-1:0] rd_clr;

  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == `EXT_IRQ_OFF_CTRL) || (addr == `EXT_IRQ_OFF_STATUS) ||
           (addr == `EXT_IRQ_OFF_MASK) || (addr == `EXT_IRQ_OFF_PEND);
  endfunction : is_mapped

  function automatic logic [31:0] read_word(input regs_s r, input logic [7:0] addr);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      `EXT_IRQ_OFF_CTRL: w[7:0] = r.ctrl;
      `EXT_IRQ_OFF_STATUS: w[`EXT_IRQ_STAT_W-1:0] = r.status;
      `EXT_IRQ_OFF_MASK: w[`EXT_IRQ_STAT_W-1:0] = r.mask;
      `EXT_IRQ_OFF_PEND: w[3:0] = r.req;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction : read_word

  // Pin order: 0 A3, 1 E1, 4:2 F2..0, 9:5 B4..0
  assign pins_raw = {port_b_in, port_f_in, port_e1_in, port_a3_in};

  ext_irq_pin_sync #(
    .WIDTH(10)
  ) u_sync (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in(pins_raw),
    .pins_out(pins_sync)
  );

  ext_irq_pin_sense #(
    .PINS(2)
  ) u_src0 (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in(pins_sync[1:0]),
    .mode_in(q.ctrl[`EXT_IRQ_SENSE_A_HI:`EXT_IRQ_SENSE_A_LO]),
    .invert_in(q.ctrl[`EXT_IRQ_INVERT_SRC0]),
    .edge_hit_out(edge_hit[0]),
    .level_hit_out(level_hit[0])
  );

  ext_irq_pin_sense #(
    .PINS(3)
  ) u_src1 (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in(pins_sync[4:2]),
    .mode_in(q.ctrl[`EXT_IRQ_SENSE_A_HI:`EXT_IRQ_SENSE_A_LO]),
    .invert_in(1'b0),
    .edge_hit_out(edge_hit[1]),
    .level_hit_out(level_hit[1])
  );

  ext_irq_pin_sense #(
    .PINS(4)
  ) u_src2 (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in(pins_sync[8:5]),
    .mode_in(q.ctrl[`EXT_IRQ_SENSE_B_HI:`EXT_IRQ_SENSE_B_LO]),
    .invert_in(q.ctrl[`EXT_IRQ_INVERT_SRC2]),
    .edge_hit_out(edge_hit[2]),
    .level_hit_out(level_hit[2])
  );

  ext_irq_pin_sense #(
    .PINS(1)
  ) u_src3 (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .pins_in(pins_sync[9]),
    .mode_in(q.ctrl[`EXT_IRQ_SENSE_B_HI:`EXT_IRQ_SENSE_B_LO]),
    .invert_in(1'b0),
    .edge_hit_out(edge_hit[3]),
    .level_hit_out(level_hit[3])
  );

  always_comb begin
    d = q;
    hit = edge_hit | level_hit;
    access = psel_in & penable_in & ~q.pready;
    done = psel_in & penable_in & q.pready;
    wr = done & pwrite_in & is_mapped(paddr_in);
    wr_ctrl = wr & (paddr_in == `EXT_IRQ_OFF_CTRL);
    level3 = cpu_level_hi_in & cpu_level_lo_in;
    ctrl_new = pwdata_in[7:0] & `EXT_IRQ_CTRL_WMASK;
    chg_b = ctrl_new[`EXT_IRQ_SENSE_B_HI:`EXT_IRQ_SENSE_B_LO] !=
            q.ctrl[`EXT_IRQ_SENSE_B_HI:`EXT_IRQ_SENSE_B_LO];
    chg_inv2 = ctrl_new[`EXT_IRQ_INVERT_SRC2] != q.ctrl[`EXT_IRQ_INVERT_SRC2];
    chg_a = ctrl_new[`EXT_IRQ_SENSE_A_HI:`EXT_IRQ_SENSE_A_LO] !=
            q.ctrl[`EXT_IRQ_SENSE_A_HI:`EXT_IRQ_SENSE_A_LO];
    chg_inv0 = ctrl_new[`EXT_IRQ_INVERT_SRC0] != q.ctrl[`EXT_IRQ_INVERT_SRC0];
    refused = wr_ctrl & ~level3;
    pend_clr = ext_src_ack_in;
    rd_clr = '0;

    // One wait state: pready rises in the cycle after the access phase opens
    d.pready = access;
    d.pslverr = access & ~is_mapped(paddr_in);
    d.prdata = 32'h0000_0000;
    if (access && !pwrite_in) begin
      d.prdata = read_word(q, paddr_in);
    end

    if (wr_ctrl && level3) begin
      d.ctrl = ctrl_new;
      // Invert bits reach only their own source, the shared fields two each
      pend_clr[0] = pend_clr[0] | chg_a | chg_inv0;
      pend_clr[1] = pend_clr[1] | chg_a;
      pend_clr[2] = pend_clr[2] | chg_b | chg_inv2;
      pend_clr[3] = pend_clr[3] | chg_b;
    end
    if (wr && (paddr_in == `EXT_IRQ_OFF_MASK)) begin
      d.mask = pwdata_in[`EXT_IRQ_STAT_W-1:0];
    end
    // Only bits actually returned are cleared, so a late event survives
    if (done && !pwrite_in && (paddr_in == `EXT_IRQ_OFF_STATUS)) begin
      rd_clr = q.prdata[`EXT_IRQ_STAT_W-1:0];
    end

    // New hits win over ack and over the clear caused by a control write
    d.pend = (q.pend & ~pend_clr) | edge_hit;
    d.req = d.pend | level_hit;
    events = {refused, hit};
    d.status = (q.status & ~rd_clr) | events;
    d.irq = |(d.status & d.mask);
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
      q.ctrl <= `EXT_IRQ_CTRL_RST;
      q.mask <= `EXT_IRQ_MASK_RST;
      q.status <= `EXT_IRQ_STATUS_RST;
      q.pend <= `EXT_IRQ_PEND_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata_out = q.prdata;
  assign pready_out = q.pready;
  assign pslverr_out = q.pslverr;
  assign ext_src_req_out = q.req;
  assign irq_out = q.irq;

  property p_ctrl_gated;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && !(cpu_level_hi_in && cpu_level_lo_in)) |=> $stable(q.ctrl);
  endproperty
  a_ctrl_gated: assert property (p_ctrl_gated) else $error("control changed outside level 3");

  property p_ctrl_taken;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && cpu_level_hi_in && cpu_level_lo_in)
      |=> (q.ctrl == ($past(pwdata_in[7:0]) & `EXT_IRQ_CTRL_WMASK));
  endproperty
  a_ctrl_taken: assert property (p_ctrl_taken) else $error("level 3 control write lost");

  property p_rsvd_zero;
    @(posedge mclk_in) disable iff (!nrst_in)
    q.ctrl[1:0] == 2'b00;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved control bits not zero");

  property p_clear_b;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && level3 && chg_b) |=> (q.pend[3:2] == $past(edge_hit[3:2]));
  endproperty
  a_clear_b: assert property (p_clear_b) else $error("port B pending not cleared");

  property p_clear_a;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && level3 && chg_a) |=> (q.pend[1:0] == $past(edge_hit[1:0]));
  endproperty
  a_clear_a: assert property (p_clear_a) else $error("port A/F pending not cleared");

  property p_src2_low;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[7:5] == 3'b000 && pins_sync[8:5] != 4'hF) |=> ext_src_req_out[2];
  endproperty
  a_src2_low: assert property (p_src2_low) else $error("source 2 low level missed");

  property p_src2_high;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[7:5] == 3'b001 && pins_sync[8:5] != 4'h0) |=> ext_src_req_out[2];
  endproperty
  a_src2_high: assert property (p_src2_high) else $error("source 2 high level missed");

  property p_src3_plain;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[7:5] == 3'b001 && !pins_sync[9]) |-> level_hit[3];
  endproperty
  a_src3_plain: assert property (p_src3_plain) else $error("source 3 took inversion");

  property p_src0_high;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[4:2] == 3'b001 && pins_sync[1:0] != 2'b00) |-> level_hit[0];
  endproperty
  a_src0_high: assert property (p_src0_high) else $error("source 0 high level missed");

  property p_src1_plain;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[4:2] == 3'b001 && pins_sync[4:2] == 3'h7) |-> !level_hit[1];
  endproperty
  a_src1_plain: assert property (p_src1_plain) else $error("source 1 took inversion");

  property p_src1_rise;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[4:3] == 2'b01 && $rose(pins_sync[2])) |=> ext_src_req_out[1];
  endproperty
  a_src1_rise: assert property (p_src1_rise) else $error("source 1 rising edge missed");

  property p_src3_both;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[7:6] == 2'b11 && $fell(pins_sync[9])) |=> ext_src_req_out[3];
  endproperty
  a_src3_both: assert property (p_src3_both) else $error("source 3 falling edge missed");

  property p_edge_held;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.pend[1] && ext_src_ack_in[1] == 1'b0 && !(wr_ctrl && level3))
      |=> ext_src_req_out[1];
  endproperty
  a_edge_held: assert property (p_edge_held) else $error("pending edge dropped");

  property p_irq_level;
    @(posedge mclk_in) disable iff (!nrst_in)
    (|(events & q.mask)) |=> irq_out;
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

  property p_ready_once;
    @(posedge mclk_in) disable iff (!nrst_in)
    (psel_in && penable_in && !pready_out) |=> (pready_out ##1 !pready_out);
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready timing wrong");

  property p_refused_flag;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && !level3) |=> q.status[`EXT_IRQ_STAT_REFUSED];
  endproperty
  a_refused_flag: assert property (p_refused_flag) else $error("refused write not flagged");

  property p_clear_inv2;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && level3 && chg_inv2) |=> (q.pend[2] == $past(edge_hit[2]));
  endproperty
  a_clear_inv2: assert property (p_clear_inv2) else $error("source 2 pending kept");

  property p_clear_inv0;
    @(posedge mclk_in) disable iff (!nrst_in)
    (wr_ctrl && level3 && chg_inv0) |=> (q.pend[0] == $past(edge_hit[0]));
  endproperty
  a_clear_inv0: assert property (p_clear_inv0) else $error("source 0 pending kept");

  property p_src0_low;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[4:2] == 3'b000 && pins_sync[1:0] != 2'b11) |-> level_hit[0];
  endproperty
  a_src0_low: assert property (p_src0_low) else $error("source 0 low level missed");

  property p_src1_low;
    @(posedge mclk_in) disable iff (!nrst_in)
    (q.ctrl[4:3] == 2'b00 && pins_sync[4:2] != 3'h7) |-> level_hit[1];
  endproperty
  a_src1_low: assert property (p_src1_low) else $error("source 1 low level missed");

endmodule : ext_irq_sensitivity

// ### tb/pin_side_model.sv
`timescale 1ns/10ps

module pin_side_model (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic [9:0] pins_in,
  input wire logic ack_now_in,
  input wire logic [3:0] ext_src_req_in,
  output logic port_a3_out,
  output logic port_e1_out,
  output logic [2:0] port_f_out,
  output logic [4:0] port_b_out,
  output logic [3:0] ext_src_ack_out
);
  assign port_a3_out = pins_in[0];
  assign port_e1_out = pins_in[1];
  assign port_f_out = pins_in[4:2];
  assign port_b_out = pins_in[9:5];

  // Only sources that are requesting get acknowledged, one cycle after the command
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ext_src_ack_out <= 4'h0;
    end else begin
      ext_src_ack_out <= ack_now_in ? ext_src_req_in : 4'h0;
    end
  end
endmodule : pin_side_model

// ### tb/testbench.sv
`timescale 1ns/10ps
`include "ext_irq_defines.svh"

module testbench;
  logic mclk_in, nrst_in, psel, penable, pwrite, pready, pslverr, irq;
  logic lvl_hi, lvl_lo, ack_now, a3, e1, err;
  logic [7:0] paddr, c;
  logic [31:0] pwdata, prdata, q;
  logic [9:0] pins;
  logic [2:0] pf;
  logic [4:0] pb;
  logic [3:0] ack, req;
  int miscompares = 0;
  int samples_checked = 0;

  ext_irq_sensitivity u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .cpu_level_hi_in(lvl_hi), .cpu_level_lo_in(lvl_lo), .port_a3_in(a3), .port_e1_in(e1),
    .port_f_in(pf), .port_b_in(pb), .ext_src_ack_in(ack), .ext_src_req_out(req),
    .irq_out(irq));

  pin_side_model u_pins (.mclk_in(mclk_in), .nrst_in(nrst_in), .pins_in(pins),
    .ack_now_in(ack_now), .ext_src_req_in(req), .port_a3_out(a3), .port_e1_out(e1),
    .port_f_out(pf), .port_b_out(pb), .ext_src_ack_out(ack));

  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : wrap_up

  task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  // No latency is assumed here; a slave that never answers is caught by the watchdog
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_in);
    penable <= 1'b1;
    do begin
      @(posedge mclk_in);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_in);
  endtask : apb

  task rd(input string n, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(n, exp, q);
  endtask : rd

  task pulse_ack;
    ack_now <= 1'b1;
    @(posedge mclk_in);
    ack_now <= 1'b0;
    repeat (4) @(posedge mclk_in);
  endtask : pulse_ack

  function automatic logic hit(input logic [1:0] m, input logic inv, input int k);
    logic r, f, l, h;
    r = m[0];
    f = (m != 2'h1);
    l = (m == 2'h0);
    h = 1'b0;
    if (inv && m != 2'h3) begin
      r = ~r;
      f = ~f;
      h = l;
      l = 1'b0;
    end
    case (k)
      0: return r;
      1: return f;
      2: return l;
      default: return h;
    endcase
  endfunction : hit

  // Sources 1 and 3 never see an inversion bit
  function automatic logic [3:0] ex(input logic [7:0] v, input int k);
    return {hit(v[7:6], 1'b0, k), hit(v[7:6], v[5], k), hit(v[4:3], 1'b0, k),
      hit(v[4:3], v[2], k)};
  endfunction : ex

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  initial begin
    #200000;
    miscompares++;
    wrap_up();
  end

  initial begin
    nrst_in = 1'b0;
    {psel, penable, pwrite, ack_now, lvl_hi, lvl_lo} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    pins = 10'h3FF;
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    rd("ctrl", `EXT_IRQ_OFF_CTRL, 32'h0);
    rd("mask", `EXT_IRQ_OFF_MASK, 32'h0);
    for (int k = 0; k < 3; k++) begin
      {lvl_hi, lvl_lo} <= k[1:0];
      apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h90);
      rd("ctrl_refused", `EXT_IRQ_OFF_CTRL, 32'h0);
    end
    rd("status_refused", `EXT_IRQ_OFF_STATUS, 32'h10);
    {lvl_hi, lvl_lo} <= 2'h3;
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'hFC);
    rd("ctrl_all", `EXT_IRQ_OFF_CTRL, 32'hFC);
    for (int i = 0; i < 8; i++) begin
      c = {i[2:1], i[0], ~i[2:1], ~i[0], 2'b00};
      apb(1'b1, `EXT_IRQ_OFF_CTRL, {24'h0, c});
      pins <= 10'h000;
      repeat (4) @(posedge mclk_in);
      chk("req_fall", ex(c, 1) | ex(c, 2), req);
      pulse_ack();
      chk("req_low", ex(c, 2), req);
      pins <= 10'h3FF;
      repeat (4) @(posedge mclk_in);
      chk("req_rise", ex(c, 0) | ex(c, 3), req);
      pulse_ack();
      chk("req_high", ex(c, 3), req);
    end
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h90);
    for (int p = 0; p < 10; p++) begin
      pins <= ~(10'h001 << p);
      repeat (4) @(posedge mclk_in);
      chk("pin_map", 4'h1 << (p < 2 ? 0 : p < 5 ? 1 : p < 9 ? 2 : 3), req);
      pins <= 10'h3FF;
      pulse_ack();
      chk("req_acked", 4'h0, req);
    end
    pins <= 10'h000;
    repeat (4) @(posedge mclk_in);
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h90);
    chk("same_value", 4'hF, req);
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h50);
    chk("field_b_new", 4'h3, req);
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h54);
    chk("invert_a_new", 4'h2, req);
    pins <= 10'h3FF;
    apb(1'b1, `EXT_IRQ_OFF_CTRL, 32'h90);
    pulse_ack();
    apb(1'b0, `EXT_IRQ_OFF_STATUS, 32'h0);
    apb(1'b1, `EXT_IRQ_OFF_MASK, 32'h01);
    pins <= 10'h3FE;
    repeat (5) @(posedge mclk_in);
    chk("irq_on", 1'b1, irq);
    rd("pending", `EXT_IRQ_OFF_PEND, 32'h1);
    rd("status", `EXT_IRQ_OFF_STATUS, 32'h1);
    repeat (2) @(posedge mclk_in);
    chk("irq_off", 1'b0, irq);
    pins <= 10'h3DE;
    repeat (5) @(posedge mclk_in);
    chk("irq_masked", 1'b0, irq);
    rd("status_src2", `EXT_IRQ_OFF_STATUS, 32'h4);
    apb(1'b0, 8'h3C, 32'h0);
    chk("unmapped_err", 1'b1, err);
    chk("unmapped_data", 32'h0, q);
    wrap_up();
  end
endmodule : testbench
